// ---- rtscm_channel_map.v ----
// receive time slot to logical channel mapper with wishbone register access
// Operation
// - one descriptor per slot in a shared 8192 entry map for 32 ports
// - each port walks only map entries between its start and end pointers
// - descriptor bit 17 chooses direct channel or group extraction
// - direct entries give channel number in bits 13:3
// - extraction entries give group number in low 9 bits of that field
// - bit 2 enables a direct slot, forced 0 for extraction
// - bit 1 selects masked sub-channel processing for direct slots, else all 8 bits
// - bit 0 marks first slot of the channel, direct slots only
// - extraction slots take all channel fields from the group map entry
// - group entries give channel in 13:3, enable in 2, first in 0
// - group entry bit 1 selects masked processing, else all bits
// - channel numbers up to 2047 are supported
// - port receive enable ANDs every slot enable, stored maps untouched
// - group pointer gives start location and zero based slot count
// - unchannelized ports use only the start entry, end pointer ignored
`timescale 1ns/1ps
`include "rtscm_map.vh"
module rtscm_channel_map (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [18:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire o_wb_ack,
  input wire i_slot_valid,
  input wire [4:0] i_slot_port,
  input wire i_slot_frame_start,
  input wire [7:0] i_slot_data,
  output wire o_slot_ready,
  output reg o_ch_valid,
  output reg [4:0] o_ch_port,
  output reg [10:0] o_ch_number,
  output reg o_ch_mask_enable,
  output reg o_ch_first,
  output reg [7:0] o_ch_data
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PORT = 3'h1;
  localparam [2:0] S_SLOT = 3'h2;
  localparam [2:0] S_GPTR = 3'h3;
  localparam [2:0] S_GMAP = 3'h4;
  localparam [2:0] S_BUS_RD = 3'h5;
  localparam [2:0] S_BUS_END = 3'h6;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg ack_ff;
  reg [31:0] rdat_ff;
  reg [4:0] port_ff;
  reg sof_ff;
  reg [7:0] data_ff;
  reg port_en_ff;
  reg [15:0] drop_ff;

  wire [31:0] cfg_q;
  wire [12:0] pcur_q;
  wire [17:0] slot_q;
  wire [18:0] gptr_q;
  wire [5:0] gcur_q;
  wire [13:0] gmap_q;

  // bus decode
  wire bus_req = i_wb_cyc & i_wb_stb;
  wire full_word = (i_wb_sel == 4'hF);
  wire [3:0] rgn = i_wb_adr[18:15];
  wire [1:0] sub = i_wb_adr[14:13];
  wire hit_slot = (rgn == `RTSCM_RGN_SLOT_MAP);
  wire hit_gmap = (rgn == `RTSCM_RGN_GROUP_MAP);
  wire hit_gptr = (rgn == `RTSCM_RGN_MISC) && (sub == `RTSCM_SUB_GROUP_PTR) && (i_wb_adr[12:11] == 2'h0);
  wire hit_pcfg = (rgn == `RTSCM_RGN_MISC) && (sub == `RTSCM_SUB_PORT_CFG) && (i_wb_adr[12:7] == 6'h00);
  wire hit_stat = (rgn == `RTSCM_RGN_MISC) && (sub == `RTSCM_SUB_STATUS) && (i_wb_adr[12:2] == 11'h000);
  wire bus_wr = (state_ff == S_IDLE) && bus_req && i_wb_we && full_word;
  wire [12:0] bus_idx = i_wb_adr[14:2];

  // the bus wins the idle cycle; slots wait, the source sees ready low
  assign o_slot_ready = (state_ff == S_IDLE) && !bus_req;
  wire take_slot = o_slot_ready && i_slot_valid;
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  // port configuration fields
  wire [12:0] p_start = cfg_q[`RTSCM_PCFG_START_HI:`RTSCM_PCFG_START_LO];
  wire [12:0] p_end = cfg_q[`RTSCM_PCFG_END_HI:`RTSCM_PCFG_END_LO];
  wire p_unch = cfg_q[`RTSCM_PCFG_UNCH];
  wire p_en = cfg_q[`RTSCM_PCFG_RXEN];
  // unchannelized ports stay on the start entry whatever the end pointer says
  wire [12:0] slot_idx = (sof_ff || p_unch || !p_en) ? p_start : pcur_q;
  wire [12:0] nxt_pcur = (p_unch || !p_en || slot_idx == p_end) ? p_start : slot_idx + 13'h0001;

  // descriptor decode
  wire d_ext;
  wire [10:0] d_ch;
  wire [8:0] d_grp;
  wire d_en;
  wire d_mask;
  wire d_first;
  rtscm_entry_dec u_slot_dec (
    .i_entry(slot_q),
    .i_group_fmt(1'b0),
    .o_extraction_select(d_ext),
    .o_slot_channel_number(d_ch),
    .o_slot_group_number(d_grp),
    .o_slot_enable(d_en),
    .o_slot_mask_enable(d_mask),
    .o_first_slot_flag(d_first)
  );
  wire g_ext_unused;
  wire [10:0] g_ch;
  wire [8:0] g_grp_unused;
  wire g_en;
  wire g_mask;
  wire g_first;
  rtscm_entry_dec u_group_dec (
    .i_entry({4'h0, gmap_q}),
    .i_group_fmt(1'b1),
    .o_extraction_select(g_ext_unused),
    .o_slot_channel_number(g_ch),
    .o_slot_group_number(g_grp_unused),
    .o_slot_enable(g_en),
    .o_slot_mask_enable(g_mask),
    .o_first_slot_flag(g_first)
  );

  // group pointer walk
  reg [8:0] grp_ff;
  wire [12:0] g_start = gptr_q[`RTSCM_GPTR_START_HI:`RTSCM_GPTR_START_LO];
  wire [5:0] g_len = gptr_q[`RTSCM_GPTR_LEN_HI:`RTSCM_GPTR_LEN_LO];
  wire [12:0] gmap_idx = g_start + {7'h00, gcur_q};
  wire [5:0] nxt_gcur = (gcur_q == g_len) ? 6'h00 : gcur_q + 6'h01;

  // memory read addresses, driven by the state that needs them next cycle
  wire [4:0] cfg_ra = (state_ff == S_IDLE && bus_req) ? bus_idx[4:0] : i_slot_port;
  wire [12:0] slot_ra = (state_ff == S_PORT) ? slot_idx : bus_idx;
  wire [8:0] gptr_ra = (state_ff == S_SLOT) ? d_grp : bus_idx[8:0];
  wire [12:0] gmap_ra = (state_ff == S_GPTR) ? gmap_idx : bus_idx;
  // a fresh group pointer write also rewinds that group's walk
  wire gcur_we = (state_ff == S_GPTR) || (bus_wr && hit_gptr);
  wire [8:0] gcur_wa = (state_ff == S_GPTR) ? grp_ff : bus_idx[8:0];
  wire [5:0] gcur_wd = (state_ff == S_GPTR) ? nxt_gcur : 6'h00;

  rtscm_ram #(.AW(5), .DW(32)) u_port_cfg (
    .i_clk_sys(i_clk_sys),
    .i_we(bus_wr && hit_pcfg),
    .i_waddr(bus_idx[4:0]),
    .i_wdata(i_wb_dat),
    .i_raddr(cfg_ra),
    .o_rdata(cfg_q)
  );
  rtscm_ram #(.AW(5), .DW(13)) u_port_cursor (
    .i_clk_sys(i_clk_sys),
    .i_we(state_ff == S_PORT),
    .i_waddr(port_ff),
    .i_wdata(nxt_pcur),
    .i_raddr(i_slot_port),
    .o_rdata(pcur_q)
  );
  rtscm_ram #(.AW(13), .DW(18)) u_slot_map (
    .i_clk_sys(i_clk_sys),
    .i_we(bus_wr && hit_slot),
    .i_waddr(bus_idx),
    .i_wdata(i_wb_dat[17:0]),
    .i_raddr(slot_ra),
    .o_rdata(slot_q)
  );
  rtscm_ram #(.AW(9), .DW(19)) u_group_ptr (
    .i_clk_sys(i_clk_sys),
    .i_we(bus_wr && hit_gptr),
    .i_waddr(bus_idx[8:0]),
    .i_wdata(i_wb_dat[18:0]),
    .i_raddr(gptr_ra),
    .o_rdata(gptr_q)
  );
  rtscm_ram #(.AW(9), .DW(6)) u_group_cursor (
    .i_clk_sys(i_clk_sys),
    .i_we(gcur_we),
    .i_waddr(gcur_wa),
    .i_wdata(gcur_wd),
    .i_raddr(gptr_ra),
    .o_rdata(gcur_q)
  );
  rtscm_ram #(.AW(13), .DW(14)) u_group_map (
    .i_clk_sys(i_clk_sys),
    .i_we(bus_wr && hit_gmap),
    .i_waddr(bus_idx),
    .i_wdata(i_wb_dat[13:0]),
    .i_raddr(gmap_ra),
    .o_rdata(gmap_q)
  );

  // state sequencing
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (bus_req) begin
          nxt_state = i_wb_we ? S_BUS_END : S_BUS_RD;
        end else if (i_slot_valid) begin
          nxt_state = S_PORT;
        end
      end
      S_PORT: begin
        nxt_state = S_SLOT;
      end
      S_SLOT: begin
        // extraction on a port not in slot bus mode is left to software to avoid
        nxt_state = d_ext ? S_GPTR : S_IDLE;
      end
      S_GPTR: begin
        nxt_state = S_GMAP;
      end
      S_GMAP: begin
        nxt_state = S_IDLE;
      end
      S_BUS_RD: begin
        nxt_state = S_BUS_END;
      end
      S_BUS_END: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= S_IDLE;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
      port_ff <= 5'h00;
      sof_ff <= 1'b0;
      data_ff <= 8'h00;
      port_en_ff <= 1'b0;
      grp_ff <= 9'h000;
      drop_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      ack_ff <= (state_ff == S_IDLE && bus_req && i_wb_we) || (state_ff == S_BUS_RD);
      if (state_ff == S_BUS_RD) begin
        if (hit_slot) begin
          rdat_ff <= {14'h0000, slot_q};
        end else if (hit_gmap) begin
          rdat_ff <= {18'h00000, gmap_q};
        end else if (hit_gptr) begin
          rdat_ff <= {13'h0000, gptr_q};
        end else if (hit_pcfg) begin
          rdat_ff <= cfg_q;
        end else if (hit_stat) begin
          rdat_ff <= {drop_ff, 13'h0000, state_ff};
        end else begin
          rdat_ff <= 32'h00000000;
        end
      end
      if (take_slot) begin
        port_ff <= i_slot_port;
        sof_ff <= i_slot_frame_start;
        data_ff <= i_slot_data;
      end
      if (state_ff == S_PORT) begin
        port_en_ff <= p_en;
      end
      if (state_ff == S_SLOT) begin
        grp_ff <= d_grp;
      end
      // disabled slots are only counted, never delivered
      if ((state_ff == S_SLOT && !d_ext && !(port_en_ff && d_en)) ||
          (state_ff == S_GMAP && !(port_en_ff && g_en))) begin
        drop_ff <= drop_ff + 16'h0001;
      end
    end
  end

  // channel output stage
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ch_valid <= 1'b0;
      o_ch_port <= 5'h00;
      o_ch_number <= 11'h000;
      o_ch_mask_enable <= 1'b0;
      o_ch_first <= 1'b0;
      o_ch_data <= 8'h00;
    end else begin
      o_ch_valid <= 1'b0;
      if (state_ff == S_SLOT && !d_ext) begin
        o_ch_valid <= port_en_ff & d_en;
        o_ch_number <= d_ch;
        o_ch_mask_enable <= d_mask;
        o_ch_first <= d_first;
        o_ch_port <= port_ff;
        o_ch_data <= data_ff;
      end else if (state_ff == S_GMAP) begin
        o_ch_valid <= port_en_ff & g_en;
        o_ch_number <= g_ch;
        o_ch_mask_enable <= g_mask;
        o_ch_first <= g_first;
        o_ch_port <= port_ff;
        o_ch_data <= data_ff;
      end
    end
  end
endmodule // rtscm_channel_map

// ---- rtscm_map.vh ----
// constants for the receive time slot channel map: address map, field positions, sizes
`ifndef RTSCM_MAP_VH
`define RTSCM_MAP_VH
`define RTSCM_SLOT_ENTRIES 8192
`define RTSCM_PORTS 32
`define RTSCM_GROUPS 512
`define RTSCM_MAX_CHANNEL 2047
// bus regions, selected by adr[18:15]; word index in the low bits
`define RTSCM_RGN_SLOT_MAP 4'h0
`define RTSCM_RGN_GROUP_MAP 4'h1
`define RTSCM_RGN_MISC 4'h2
// sub regions of the misc region, selected by adr[14:13]
`define RTSCM_SUB_GROUP_PTR 2'h0
`define RTSCM_SUB_PORT_CFG 2'h1
`define RTSCM_SUB_STATUS 2'h2
`define RTSCM_ADDR_SLOT_MAP 19'h00000
`define RTSCM_ADDR_GROUP_MAP 19'h08000
`define RTSCM_ADDR_GROUP_PTR 19'h10000
`define RTSCM_ADDR_PORT_CFG 19'h12000
`define RTSCM_ADDR_STATUS 19'h14000
// descriptor and group map entry fields
`define RTSCM_DESC_EXT 17
`define RTSCM_DESC_CH_HI 13
`define RTSCM_DESC_CH_LO 3
`define RTSCM_DESC_GRP_HI 11
`define RTSCM_DESC_EN 2
`define RTSCM_DESC_MASK 1
`define RTSCM_DESC_FIRST 0
// group pointer entry fields
`define RTSCM_GPTR_START_HI 18
`define RTSCM_GPTR_START_LO 6
`define RTSCM_GPTR_LEN_HI 5
`define RTSCM_GPTR_LEN_LO 0
// port configuration word fields
`define RTSCM_PCFG_START_HI 12
`define RTSCM_PCFG_START_LO 0
`define RTSCM_PCFG_RXEN 13
`define RTSCM_PCFG_END_HI 28
`define RTSCM_PCFG_END_LO 16
`define RTSCM_PCFG_UNCH 29
`define RTSCM_PCFG_MULTIPLEXED_SLOT_BUS_MODE 30
`endif

// ---- rtscm_ram.v ----
// simple dual port memory with registered read data
`timescale 1ns/1ps
module rtscm_ram #(
  parameter AW = 13,
  parameter DW = 18
) (
  input wire i_clk_sys,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem_ff [0:(1<<AW)-1];

  // contents carry no reset: software must load them before enabling a port
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_ff[i_raddr];
  end
endmodule // rtscm_ram

// ---- rtscm_entry_dec.v ----
// field decoder for a slot descriptor or a group map entry
`timescale 1ns/1ps
`include "rtscm_map.vh"
module rtscm_entry_dec (
  input wire [17:0] i_entry,
  input wire i_group_fmt,
  output wire o_extraction_select,
  output wire [10:0] o_slot_channel_number,
  output wire [8:0] o_slot_group_number,
  output wire o_slot_enable,
  output wire o_slot_mask_enable,
  output wire o_first_slot_flag
);
  // a group entry has no extraction bit; its upper bits are reserved
  assign o_extraction_select = i_entry[`RTSCM_DESC_EXT] & ~i_group_fmt;
  assign o_slot_channel_number = i_entry[`RTSCM_DESC_CH_HI:`RTSCM_DESC_CH_LO];
  assign o_slot_group_number = i_entry[`RTSCM_DESC_GRP_HI:`RTSCM_DESC_CH_LO];
  assign o_slot_enable = i_entry[`RTSCM_DESC_EN] & ~o_extraction_select;
  assign o_slot_mask_enable = i_entry[`RTSCM_DESC_MASK] & ~o_extraction_select;
  assign o_first_slot_flag = i_entry[`RTSCM_DESC_FIRST] & ~o_extraction_select;
endmodule // rtscm_entry_dec

// ---- rtscm_chk.sv ----
// port assertions for the receive slot channel mapper
`timescale 1ns/1ps
module rtscm_chk (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire i_slot_valid,
  input wire [7:0] i_slot_data,
  input wire o_wb_ack,
  input wire o_slot_ready,
  input wire o_ch_valid,
  input wire [7:0] o_ch_data
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  wire req = i_wb_cyc && i_wb_stb;
  wire take = i_slot_valid && o_slot_ready;
  // idle state is only visible as ready high with nothing offered
  sequence idle_req;
    (!req && o_slot_ready && !i_slot_valid) ##1 req;
  endsequence
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_cause: assert property (o_wb_ack |-> $past(req)) else $error("ack without request");
  a_wr_ack_lat: assert property (idle_req ##0 i_wb_we |=> o_wb_ack) else $error("write ack late");
  a_rd_ack_lat: assert property (idle_req ##0 !i_wb_we |=> !o_wb_ack ##1 o_wb_ack) else $error("read ack");
  a_bus_first: assert property (req |-> !o_slot_ready) else $error("slot taken during bus access");
  a_slot_busy: assert property (take |=> !o_slot_ready [*2]) else $error("slot taken mid lookup");
  a_no_early: assert property (take |=> !o_ch_valid [*2]) else $error("early delivery");
  a_ch_cause: assert property (o_ch_valid |-> $past(take, 3) || $past(take, 5)) else $error("stray delivery");
  a_slot_data: assert property (o_ch_valid |->
    o_ch_data == ($past(take, 3) ? $past(i_slot_data, 3) : $past(i_slot_data, 5))) else $error("slot bits altered");
endmodule // rtscm_chk

// ---- rtscm_slot_src.sv ----
// serial port side model: offers one received slot at a time
`timescale 1ns/1ps
module rtscm_slot_src (
  input wire i_clk_sys,
  input wire i_ready,
  output logic o_valid = 1'b0,
  output logic [4:0] o_port = 5'h00,
  output logic o_frame_start = 1'b0,
  output logic [7:0] o_data = 8'h00
);
  task automatic send(input logic [4:0] p, input logic fs, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_valid <= 1'b1;
    o_port <= p;
    o_frame_start <= fs;
    o_data <= d;
    do @(posedge i_clk_sys); while (i_ready !== 1'b1);
    o_valid <= 1'b0;
    // released port and data lines go inverse so stale bits cannot pass as fresh
    o_port <= ~p;
    o_data <= ~d;
  endtask
endmodule // rtscm_slot_src

// ---- rtscm_channel_map_tb.sv ----
// self-checking testbench for the receive slot channel mapper
`timescale 1ns/1ps
`include "rtscm_map.vh"
module rtscm_channel_map_tb;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [18:0] i_wb_adr = 19'h00000;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h00000000;
  wire [31:0] o_wb_dat;
  wire [10:0] o_ch_number;
  wire [7:0] i_slot_data, o_ch_data;
  wire [4:0] i_slot_port, o_ch_port;
  wire o_wb_ack, i_slot_valid, i_slot_frame_start, o_slot_ready, o_ch_valid, o_ch_mask_enable, o_ch_first;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] q, s0;
  always #5 i_clk_sys = ~i_clk_sys;
  rtscm_channel_map dut (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_slot_valid(i_slot_valid),
    .i_slot_port(i_slot_port),
    .i_slot_frame_start(i_slot_frame_start),
    .i_slot_data(i_slot_data),
    .o_slot_ready(o_slot_ready),
    .o_ch_valid(o_ch_valid),
    .o_ch_port(o_ch_port),
    .o_ch_number(o_ch_number),
    .o_ch_mask_enable(o_ch_mask_enable),
    .o_ch_first(o_ch_first),
    .o_ch_data(o_ch_data)
  );
  rtscm_slot_src src (.i_clk_sys(i_clk_sys), .i_ready(o_slot_ready), .o_valid(i_slot_valid),
    .o_port(i_slot_port), .o_frame_start(i_slot_frame_start), .o_data(i_slot_data));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic we, input logic [18:0] base, input int i, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk_sys);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= base + 19'(i * 4);
    i_wb_dat <= d;
    i_wb_sel <= s;
    do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [18:0] base, input int i, input logic [31:0] d);
    acc(1'b1, base, i, d, 4'hF);
  endtask
  task automatic rd(input logic [18:0] base, input int i, input logic [31:0] exp);
    acc(1'b0, base, i, 32'h0, 4'hF);
    chk(q, exp);
  endtask
  function automatic logic [31:0] ent(input logic x, input logic [10:0] ch, input logic [2:0] emf);
    return {14'h0, x, 3'h0, ch, emf};
  endfunction
  function automatic logic [31:0] pc(input logic [12:0] st, input logic [12:0] e, input logic en, input logic [1:0] tu);
    return {1'b0, tu, e, 2'h0, en, st};
  endfunction
  // e holds channel, enable, mask, first; a clear enable means nothing may arrive
  task automatic sl(input logic [4:0] p, input logic fs, input logic [7:0] d, input logic [13:0] e);
    int n;
    n = 0;
    src.send(p, fs, d);
    while (o_ch_valid !== 1'b1 && n < 6) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (e[2]) chk({o_ch_valid, o_ch_port, o_ch_number, o_ch_mask_enable, o_ch_first, o_ch_data}, {1'b1, p, e[13:3], e[1:0], d});
    else chk(o_ch_valid, 1'b0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    wr(`RTSCM_ADDR_PORT_CFG, 3, pc(13'h1FFE, 13'h1FFF, 1'b1, 2'h0));
    wr(`RTSCM_ADDR_SLOT_MAP, 8190, 32'hFFFC0000 | ent(1'b0, 11'h7FF, 3'h7));
    wr(`RTSCM_ADDR_SLOT_MAP, 8191, ent(1'b0, 11'h001, 3'h5));
    rd(`RTSCM_ADDR_SLOT_MAP, 8190, ent(1'b0, 11'h7FF, 3'h7));
    sl(5'h03, 1'b1, 8'hA5, {11'h7FF, 3'h7});
    sl(5'h03, 1'b0, 8'h5A, {11'h001, 3'h5});
    sl(5'h03, 1'b0, 8'hC3, {11'h7FF, 3'h7});
    wr(`RTSCM_ADDR_SLOT_MAP, 8191, ent(1'b0, 11'h009, 3'h3));
    acc(1'b1, `RTSCM_ADDR_SLOT_MAP, 8191, 32'h00000004, 4'h3);
    rd(`RTSCM_ADDR_SLOT_MAP, 8191, ent(1'b0, 11'h009, 3'h3));
    rd(19'h7FFFC, 0, 32'h00000000);
    acc(1'b0, `RTSCM_ADDR_STATUS, 0, 32'h0, 4'hF);
    s0 = q;
    sl(5'h03, 1'b0, 8'h11, {11'h009, 3'h3});
    wr(`RTSCM_ADDR_PORT_CFG, 3, pc(13'h1FFE, 13'h1FFF, 1'b0, 2'h0));
    sl(5'h03, 1'b1, 8'h22, 14'h0000);
    wr(`RTSCM_ADDR_STATUS, 0, 32'h00000000);
    acc(1'b0, `RTSCM_ADDR_STATUS, 0, 32'h0, 4'hF);
    chk(q[31:16], s0[31:16] + 16'h0002);
    wr(`RTSCM_ADDR_PORT_CFG, 3, pc(13'h1FFE, 13'h1FFF, 1'b1, 2'h0));
    sl(5'h03, 1'b1, 8'h33, {11'h7FF, 3'h7});
    wr(`RTSCM_ADDR_SLOT_MAP, 20, ent(1'b1, 11'h7FF, 3'h7));
    wr(`RTSCM_ADDR_GROUP_PTR, 511, {13'h0, 13'h0064, 6'h01});
    wr(`RTSCM_ADDR_GROUP_MAP, 100, ent(1'b0, 11'h003, 3'h7));
    wr(`RTSCM_ADDR_GROUP_MAP, 101, ent(1'b0, 11'h400, 3'h5));
    // the port is enabled only once its groups are set up and idle
    wr(`RTSCM_ADDR_PORT_CFG, 7, pc(13'h0014, 13'h0014, 1'b1, 2'h2));
    sl(5'h07, 1'b1, 8'h81, {11'h003, 3'h7});
    sl(5'h07, 1'b1, 8'h82, {11'h400, 3'h5});
    sl(5'h07, 1'b1, 8'h83, {11'h003, 3'h7});
    wr(`RTSCM_ADDR_PORT_CFG, 9, pc(13'h001E, 13'h0005, 1'b1, 2'h1));
    wr(`RTSCM_ADDR_SLOT_MAP, 30, ent(1'b0, 11'h04D, 3'h5));
    wr(`RTSCM_ADDR_SLOT_MAP, 31, ent(1'b0, 11'h04E, 3'h4));
    sl(5'h09, 1'b1, 8'h44, {11'h04D, 3'h5});
    sl(5'h09, 1'b0, 8'h55, {11'h04D, 3'h5});
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_mismatch++;
    complete_run;
  end
endmodule // rtscm_channel_map_tb
bind rtscm_channel_map rtscm_chk u_chk (
  .i_clk_sys(i_clk_sys),
  .i_arst_n(i_arst_n),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we),
  .i_slot_valid(i_slot_valid),
  .i_slot_data(i_slot_data),
  .o_wb_ack(o_wb_ack),
  .o_slot_ready(o_slot_ready),
  .o_ch_valid(o_ch_valid),
  .o_ch_data(o_ch_data)
);
